// [hw/ifb_pkg.sv]
package ifb_pkg;

  // register bus shape
  localparam int unsigned IFB_AW = 8;
  localparam int unsigned IFB_DW = 16;

  // register offsets on the plain port
  localparam logic [7:0] IFB_OFF_FLAGS2 = 8'h00;
  localparam logic [7:0] IFB_OFF_FLAGS3 = 8'h01;
  localparam logic [7:0] IFB_OFF_FLAGS4 = 8'h02;
  localparam logic [7:0] IFB_OFF_EN0    = 8'h03;
  localparam logic [7:0] IFB_OFF_EN2    = 8'h04;
  localparam logic [7:0] IFB_OFF_EN3    = 8'h05;
  localparam logic [7:0] IFB_OFF_EN4    = 8'h06;
  localparam logic [7:0] IFB_OFF_CLR2   = 8'h07;
  localparam logic [7:0] IFB_OFF_CLR3   = 8'h08;
  localparam logic [7:0] IFB_OFF_CLR4   = 8'h09;

  // value after reset and implemented-bit masks
  localparam logic [15:0] IFB_RST_WORD  = 16'h0000;
  localparam logic [15:0] IFB_IMPL_W2   = 16'h0007;
  localparam logic [15:0] IFB_IMPL_W3   = 16'ha7ff;
  localparam logic [15:0] IFB_IMPL_W4   = 16'h00f7;
  localparam logic [15:0] IFB_IMPL_EN0  = 16'h7fff;

  // flag word 2, low bits
  localparam int IFB_B_CAN1_RX_READY   = 2;
  localparam int IFB_B_SERIAL2_EVENT   = 1;
  localparam int IFB_B_SERIAL2_ERROR   = 0;

  // flag word 3
  localparam int IFB_B_MOTOR_FAULT_A   = 15;
  localparam int IFB_B_DMA_CH5_DONE    = 13;
  localparam int IFB_B_ENCODER_EVENT   = 10;
  localparam int IFB_B_PWM_ERROR       = 9;
  localparam int IFB_B_CAN2_EVENT      = 8;
  localparam int IFB_B_CAN2_RX_READY   = 7;
  localparam int IFB_B_EXT_IRQ4        = 6;
  localparam int IFB_B_EXT_IRQ3        = 5;
  localparam int IFB_B_TIMER_NINE      = 4;
  localparam int IFB_B_TIMER_EIGHT     = 3;
  localparam int IFB_B_I2C2_MASTER     = 2;
  localparam int IFB_B_I2C2_SLAVE      = 1;
  localparam int IFB_B_TIMER_SEVEN     = 0;

  // flag word 4
  localparam int IFB_B_CAN2_TX_REQUEST = 7;
  localparam int IFB_B_CAN1_TX_REQUEST = 6;
  localparam int IFB_B_DMA_CH7_DONE    = 5;
  localparam int IFB_B_DMA_CH6_DONE    = 4;
  localparam int IFB_B_UART2_ERROR     = 2;
  localparam int IFB_B_UART1_ERROR     = 1;
  localparam int IFB_B_MOTOR_FAULT_B   = 0;

  // enable word 0
  localparam int IFB_E_DMA_CH1_DONE    = 14;
  localparam int IFB_E_ADC1_DONE       = 13;
  localparam int IFB_E_UART1_TX        = 12;
  localparam int IFB_E_UART1_RX        = 11;
  localparam int IFB_E_SERIAL1_EVENT   = 10;
  localparam int IFB_E_SERIAL1_ERROR   = 9;
  localparam int IFB_E_TIMER_THREE     = 8;
  localparam int IFB_E_TIMER_TWO       = 7;
  localparam int IFB_E_OUT_COMPARE2    = 6;
  localparam int IFB_E_IN_CAPTURE2     = 5;
  localparam int IFB_E_DMA_CH0_DONE    = 4;
  localparam int IFB_E_TIMER_ONE       = 3;
  localparam int IFB_E_OUT_COMPARE1    = 2;
  localparam int IFB_E_IN_CAPTURE1     = 1;
  localparam int IFB_E_EXT_IRQ0        = 0;

endpackage

// [hw/ifb_word.sv]
`timescale 1ns/100ps
module ifb_word
  import ifb_pkg::*;
#(
  parameter logic [15:0] IMPL = 16'hffff
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] evt,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_flag,
  input  wire logic        clr_flag,
  input  wire logic        wr_en,
  output logic      [15:0] flag,
  output logic      [15:0] en,
  output logic      [15:0] req
);

  typedef struct packed {
    logic [15:0] flag;
    logic [15:0] en;
  } ifb_word_st_t;

  ifb_word_st_t st_q;
  ifb_word_st_t st_d;

  // software write or clear first, then events on top so a set beats a clear
  always_comb begin
    st_d = st_q;
    if (wr_flag) begin
      st_d.flag = wdata;
    end
    if (clr_flag) begin
      st_d.flag = st_q.flag & ~wdata;
    end
    st_d.flag = (st_d.flag | evt) & IMPL;
    if (wr_en) begin
      st_d.en = wdata & IMPL;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= {IFB_RST_WORD, IFB_RST_WORD};
    end else begin
      st_q <= st_d;
    end
  end

  // outputs of the word
  assign flag = st_q.flag;
  assign en   = st_q.en;
  assign req  = st_q.flag & st_q.en;

endmodule

// [hw/ifb_bank.sv]
// How it works
// - a flag reads one after its source raised a request, zero otherwise
// - an enable bit of one lets its source request, zero blocks it
// - unimplemented flag and enable bits ignore writes and read zero
// - software may read and write every implemented flag and enable bit
// - all flag and enable bits are zero after reset
// - word 2: bit 2 can1 rx ready, bit 1 serial2 event, bit 0 serial2 error
// - word 3: bit 15 motor fault a, bit 13 dma5 done; 14, 12, 11 absent
// - word 3: bits 10..7 encoder, pwm error, can2 event, can2 rx ready
// - word 3: bits 6..0 ext4, ext3, timer9, timer8, i2c2 master, slave, timer7
// - word 4: bits 15..8 and 3 absent; bits 7, 6 can2, can1 tx request
// - word 4: dma7, dma6 done; uart2, uart1 error; bit 0 motor fault b
// - enable word 0: bit 15 absent; bits 14..8 dma1 down to timer3
// - enable word 0: bits 7..0 timer2 down to external irq 0
// - enable word 0: bit 2 compare1, bit 1 capture1, bit 0 ext irq 0
`timescale 1ns/100ps
module ifb_bank
  import ifb_pkg::*;
(
  // clock, reset and register bus
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  output logic             IRQ,

  // flag word 0 is kept outside, only its gating lives here
  input  wire logic [15:0] FLAGS_W0,

  // event inputs of flag word 2
  input  wire logic        CAN1_RX_READY_FLAG,
  input  wire logic        SERIAL_PERIPH2_EVENT_FLAG,
  input  wire logic        SERIAL_PERIPH2_ERROR_FLAG,

  // event inputs of flag word 3
  input  wire logic        MOTOR_FAULT_A_FLAG,
  input  wire logic        DMA_CH5_DONE_FLAG,
  input  wire logic        ENCODER_EVENT_FLAG,
  input  wire logic        MOTOR_PWM_ERROR_FLAG,
  input  wire logic        CAN2_EVENT_FLAG,
  input  wire logic        CAN2_RX_READY_FLAG,
  input  wire logic        EXT_IRQ4_FLAG,
  input  wire logic        EXT_IRQ3_FLAG,
  input  wire logic        TIMER_NINE_FLAG,
  input  wire logic        TIMER_EIGHT_FLAG,
  input  wire logic        I2C_SECOND_MASTER_FLAG,
  input  wire logic        I2C_SECOND_SLAVE_FLAG,
  input  wire logic        TIMER_SEVEN_FLAG,

  // event inputs of flag word 4
  input  wire logic        CAN2_TX_REQUEST_FLAG,
  input  wire logic        CAN1_TX_REQUEST_FLAG,
  input  wire logic        DMA_CH7_DONE_FLAG,
  input  wire logic        DMA_CH6_DONE_FLAG,
  input  wire logic        UART_SECOND_ERROR_FLAG,
  input  wire logic        UART_FIRST_ERROR_FLAG,
  input  wire logic        MOTOR_FAULT_B_FLAG,

  // request lines of word 2
  output logic             REQ_CAN1_RX_READY,
  output logic             REQ_SERIAL_PERIPH2_EVENT,
  output logic             REQ_SERIAL_PERIPH2_ERROR,

  // request lines of word 3
  output logic             REQ_MOTOR_FAULT_A,
  output logic             REQ_DMA_CH5_DONE,
  output logic             REQ_ENCODER_EVENT,
  output logic             REQ_MOTOR_PWM_ERROR,
  output logic             REQ_CAN2_EVENT,
  output logic             REQ_CAN2_RX_READY,
  output logic             REQ_EXT_IRQ4,
  output logic             REQ_EXT_IRQ3,
  output logic             REQ_TIMER_NINE,
  output logic             REQ_TIMER_EIGHT,
  output logic             REQ_I2C_SECOND_MASTER,
  output logic             REQ_I2C_SECOND_SLAVE,
  output logic             REQ_TIMER_SEVEN,

  // request lines of word 4
  output logic             REQ_CAN2_TX_REQUEST,
  output logic             REQ_CAN1_TX_REQUEST,
  output logic             REQ_DMA_CH7_DONE,
  output logic             REQ_DMA_CH6_DONE,
  output logic             REQ_UART_SECOND_ERROR,
  output logic             REQ_UART_FIRST_ERROR,
  output logic             REQ_MOTOR_FAULT_B,

  // request lines gated by enable word 0
  output logic             REQ_DMA_CH1_DONE,
  output logic             REQ_ADC_FIRST_DONE,
  output logic             REQ_UART_FIRST_TX,
  output logic             REQ_UART_FIRST_RX,
  output logic             REQ_SERIAL_PERIPH1_EVENT,
  output logic             REQ_SERIAL_PERIPH1_ERROR,
  output logic             REQ_TIMER_THREE,
  output logic             REQ_TIMER_TWO,
  output logic             REQ_OUT_COMPARE2,
  output logic             REQ_IN_CAPTURE2,
  output logic             REQ_DMA_CH0_DONE,
  output logic             REQ_TIMER_ONE,
  output logic             REQ_OUT_COMPARE1,
  output logic             REQ_IN_CAPTURE1,
  output logic             REQ_EXT_IRQ0
);

  typedef struct packed {
    logic [15:0] rdata;
    logic        irq;
    logic [15:0] en0;
    logic [15:0] req0;
    logic [15:0] req2;
    logic [15:0] req3;
    logic [15:0] req4;
  } ifb_bank_st_t;

  ifb_bank_st_t st_q;
  ifb_bank_st_t st_d;

  logic [15:0] evt2;
  logic [15:0] evt3;
  logic [15:0] evt4;
  logic [15:0] flag2;
  logic [15:0] flag3;
  logic [15:0] flag4;
  logic [15:0] en2;
  logic [15:0] en3;
  logic [15:0] en4;
  logic [15:0] req2;
  logic [15:0] req3;
  logic [15:0] req4;
  logic [15:0] rd_word;

  // per-word request summaries
  logic        pend0;
  logic        pend2;
  logic        pend3;
  logic        pend4;

  // decoded write strobes
  logic        wr_flags2;
  logic        wr_flags3;
  logic        wr_flags4;
  logic        wr_en0;
  logic        wr_en2;
  logic        wr_en3;
  logic        wr_en4;
  logic        wr_clr2;
  logic        wr_clr3;
  logic        wr_clr4;

  // event lanes of flag word 2; the upper bits lie outside this bank
  always_comb begin
    evt2                      = 16'h0000;
    evt2[IFB_B_CAN1_RX_READY] = CAN1_RX_READY_FLAG;
    evt2[IFB_B_SERIAL2_EVENT] = SERIAL_PERIPH2_EVENT_FLAG;
    evt2[IFB_B_SERIAL2_ERROR] = SERIAL_PERIPH2_ERROR_FLAG;
  end

  // event lanes of flag word 3; bits 14, 12, 11 stay empty
  always_comb begin
    evt3                       = 16'h0000;
    evt3[IFB_B_MOTOR_FAULT_A]  = MOTOR_FAULT_A_FLAG;
    evt3[IFB_B_DMA_CH5_DONE]   = DMA_CH5_DONE_FLAG;
    evt3[IFB_B_ENCODER_EVENT]  = ENCODER_EVENT_FLAG;
    evt3[IFB_B_PWM_ERROR]      = MOTOR_PWM_ERROR_FLAG;
    evt3[IFB_B_CAN2_EVENT]     = CAN2_EVENT_FLAG;
    evt3[IFB_B_CAN2_RX_READY]  = CAN2_RX_READY_FLAG;
    evt3[IFB_B_EXT_IRQ4]       = EXT_IRQ4_FLAG;
    evt3[IFB_B_EXT_IRQ3]       = EXT_IRQ3_FLAG;
    evt3[IFB_B_TIMER_NINE]     = TIMER_NINE_FLAG;
    evt3[IFB_B_TIMER_EIGHT]    = TIMER_EIGHT_FLAG;
    evt3[IFB_B_I2C2_MASTER]    = I2C_SECOND_MASTER_FLAG;
    evt3[IFB_B_I2C2_SLAVE]     = I2C_SECOND_SLAVE_FLAG;
    evt3[IFB_B_TIMER_SEVEN]    = TIMER_SEVEN_FLAG;
  end

  // event lanes of flag word 4; upper byte and bit 3 stay empty
  always_comb begin
    evt4                        = 16'h0000;
    evt4[IFB_B_CAN2_TX_REQUEST] = CAN2_TX_REQUEST_FLAG;
    evt4[IFB_B_CAN1_TX_REQUEST] = CAN1_TX_REQUEST_FLAG;
    evt4[IFB_B_DMA_CH7_DONE]    = DMA_CH7_DONE_FLAG;
    evt4[IFB_B_DMA_CH6_DONE]    = DMA_CH6_DONE_FLAG;
    evt4[IFB_B_UART2_ERROR]     = UART_SECOND_ERROR_FLAG;
    evt4[IFB_B_UART1_ERROR]     = UART_FIRST_ERROR_FLAG;
    evt4[IFB_B_MOTOR_FAULT_B]   = MOTOR_FAULT_B_FLAG;
  end

  // address decode done once; an unmapped index matches no strobe and is dropped
  always_comb begin
    wr_flags2 = WR && (ADDR == IFB_OFF_FLAGS2);
    wr_flags3 = WR && (ADDR == IFB_OFF_FLAGS3);
    wr_flags4 = WR && (ADDR == IFB_OFF_FLAGS4);
    wr_en0    = WR && (ADDR == IFB_OFF_EN0);
    wr_en2    = WR && (ADDR == IFB_OFF_EN2);
    wr_en3    = WR && (ADDR == IFB_OFF_EN3);
    wr_en4    = WR && (ADDR == IFB_OFF_EN4);
    wr_clr2   = WR && (ADDR == IFB_OFF_CLR2);
    wr_clr3   = WR && (ADDR == IFB_OFF_CLR3);
    wr_clr4   = WR && (ADDR == IFB_OFF_CLR4);
  end

  // one flag/enable pair per word, masks keep absent bits at zero
  ifb_word #(.IMPL(IFB_IMPL_W2)) u_word2 (
    .clk      (CLK),
    .rst_n    (RST_N),
    .evt      (evt2),
    .wdata    (WDATA),
    .wr_flag  (wr_flags2),
    .clr_flag (wr_clr2),
    .wr_en    (wr_en2),
    .flag     (flag2),
    .en       (en2),
    .req      (req2)
  );

  ifb_word #(.IMPL(IFB_IMPL_W3)) u_word3 (
    .clk      (CLK),
    .rst_n    (RST_N),
    .evt      (evt3),
    .wdata    (WDATA),
    .wr_flag  (wr_flags3),
    .clr_flag (wr_clr3),
    .wr_en    (wr_en3),
    .flag     (flag3),
    .en       (en3),
    .req      (req3)
  );

  ifb_word #(.IMPL(IFB_IMPL_W4)) u_word4 (
    .clk      (CLK),
    .rst_n    (RST_N),
    .evt      (evt4),
    .wdata    (WDATA),
    .wr_flag  (wr_flags4),
    .clr_flag (wr_clr4),
    .wr_en    (wr_en4),
    .flag     (flag4),
    .en       (en4),
    .req      (req4)
  );

  // one summary bit per word keeps the interrupt or shallow
  always_comb begin
    pend0 = |st_q.req0;
    pend2 = |st_q.req2;
    pend3 = |st_q.req3;
    pend4 = |st_q.req4;
  end

  // read mux; clear words and unmapped indices read zero
  always_comb begin
    case (ADDR)
      IFB_OFF_FLAGS2: rd_word = flag2;
      IFB_OFF_FLAGS3: rd_word = flag3;
      IFB_OFF_FLAGS4: rd_word = flag4;
      IFB_OFF_EN0:    rd_word = st_q.en0;
      IFB_OFF_EN2:    rd_word = en2;
      IFB_OFF_EN3:    rd_word = en3;
      IFB_OFF_EN4:    rd_word = en4;
      default:        rd_word = 16'h0000;
    endcase
  end

  // enable word 0, request and interrupt registers
  always_comb begin
    st_d = st_q;
    if (wr_en0) begin
      st_d.en0 = WDATA & IFB_IMPL_EN0;
    end
    // the word 0 flags live elsewhere, only their gating is done here
    st_d.req0 = FLAGS_W0 & st_q.en0;
    st_d.req2 = req2;
    st_d.req3 = req3;
    st_d.req4 = req4;
    // two cycles behind the flags, one behind the registered requests, but keeps IRQ glitch free
    st_d.irq  = pend0 | pend2 | pend3 | pend4;
    // read data stand for one cycle only, zero otherwise
    st_d.rdata = 16'h0000;
    if (RD) begin
      st_d.rdata = rd_word;
    end
  end

  // state register
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs, all straight from st_q
  assign RDATA = st_q.rdata;
  assign IRQ   = st_q.irq;

  // named request lines of word 2
  assign REQ_CAN1_RX_READY        = st_q.req2[IFB_B_CAN1_RX_READY];
  assign REQ_SERIAL_PERIPH2_EVENT = st_q.req2[IFB_B_SERIAL2_EVENT];
  assign REQ_SERIAL_PERIPH2_ERROR = st_q.req2[IFB_B_SERIAL2_ERROR];

  // named request lines of word 3
  assign REQ_MOTOR_FAULT_A        = st_q.req3[IFB_B_MOTOR_FAULT_A];
  assign REQ_DMA_CH5_DONE         = st_q.req3[IFB_B_DMA_CH5_DONE];
  assign REQ_ENCODER_EVENT        = st_q.req3[IFB_B_ENCODER_EVENT];
  assign REQ_MOTOR_PWM_ERROR      = st_q.req3[IFB_B_PWM_ERROR];
  assign REQ_CAN2_EVENT           = st_q.req3[IFB_B_CAN2_EVENT];
  assign REQ_CAN2_RX_READY        = st_q.req3[IFB_B_CAN2_RX_READY];
  assign REQ_EXT_IRQ4             = st_q.req3[IFB_B_EXT_IRQ4];
  assign REQ_EXT_IRQ3             = st_q.req3[IFB_B_EXT_IRQ3];
  assign REQ_TIMER_NINE           = st_q.req3[IFB_B_TIMER_NINE];
  assign REQ_TIMER_EIGHT          = st_q.req3[IFB_B_TIMER_EIGHT];
  assign REQ_I2C_SECOND_MASTER    = st_q.req3[IFB_B_I2C2_MASTER];
  assign REQ_I2C_SECOND_SLAVE     = st_q.req3[IFB_B_I2C2_SLAVE];
  assign REQ_TIMER_SEVEN          = st_q.req3[IFB_B_TIMER_SEVEN];

  // named request lines of word 4
  assign REQ_CAN2_TX_REQUEST      = st_q.req4[IFB_B_CAN2_TX_REQUEST];
  assign REQ_CAN1_TX_REQUEST      = st_q.req4[IFB_B_CAN1_TX_REQUEST];
  assign REQ_DMA_CH7_DONE         = st_q.req4[IFB_B_DMA_CH7_DONE];
  assign REQ_DMA_CH6_DONE         = st_q.req4[IFB_B_DMA_CH6_DONE];
  assign REQ_UART_SECOND_ERROR    = st_q.req4[IFB_B_UART2_ERROR];
  assign REQ_UART_FIRST_ERROR     = st_q.req4[IFB_B_UART1_ERROR];
  assign REQ_MOTOR_FAULT_B        = st_q.req4[IFB_B_MOTOR_FAULT_B];

  // named request lines gated by enable word 0
  assign REQ_DMA_CH1_DONE         = st_q.req0[IFB_E_DMA_CH1_DONE];
  assign REQ_ADC_FIRST_DONE       = st_q.req0[IFB_E_ADC1_DONE];
  assign REQ_UART_FIRST_TX        = st_q.req0[IFB_E_UART1_TX];
  assign REQ_UART_FIRST_RX        = st_q.req0[IFB_E_UART1_RX];
  assign REQ_SERIAL_PERIPH1_EVENT = st_q.req0[IFB_E_SERIAL1_EVENT];
  assign REQ_SERIAL_PERIPH1_ERROR = st_q.req0[IFB_E_SERIAL1_ERROR];
  assign REQ_TIMER_THREE          = st_q.req0[IFB_E_TIMER_THREE];
  assign REQ_TIMER_TWO            = st_q.req0[IFB_E_TIMER_TWO];
  assign REQ_OUT_COMPARE2         = st_q.req0[IFB_E_OUT_COMPARE2];
  assign REQ_IN_CAPTURE2          = st_q.req0[IFB_E_IN_CAPTURE2];
  assign REQ_DMA_CH0_DONE         = st_q.req0[IFB_E_DMA_CH0_DONE];
  assign REQ_TIMER_ONE            = st_q.req0[IFB_E_TIMER_ONE];
  assign REQ_OUT_COMPARE1         = st_q.req0[IFB_E_OUT_COMPARE1];
  assign REQ_IN_CAPTURE1          = st_q.req0[IFB_E_IN_CAPTURE1];
  assign REQ_EXT_IRQ0             = st_q.req0[IFB_E_EXT_IRQ0];

endmodule

// [tb/ifb_bank_props.sv]
`timescale 1ns/100ps
module ifb_bank_props
  import ifb_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  ADDR,
  input  wire logic        RD,
  input  wire logic [15:0] RDATA,
  input  wire logic        IRQ,
  input  wire logic [15:0] FLAGS_W0,
  input  wire logic        TIMER_SEVEN_FLAG,
  input  wire logic        REQ_TIMER_SEVEN,
  input  wire logic        REQ_EXT_IRQ0
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // read data only in the cycle after a read strobe
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data present without a read");
  // reset clears every output, so no disable here
  a_rst_clear: assert property (disable iff (1'b0) !RST_N |=>
    RDATA == 16'h0000 && !IRQ && !REQ_TIMER_SEVEN)
    else $error("outputs not cleared by reset");
  a_unmapped_zero: assert property (RD && ADDR > IFB_OFF_CLR4 |=> RDATA == 16'h0000)
    else $error("unmapped read not zero");
  a_flags3_gap: assert property (RD && ADDR == IFB_OFF_FLAGS3 |=>
    !RDATA[14] && RDATA[12:11] == 2'b00)
    else $error("absent bits of flag word 3 not zero");
  a_flags4_gap: assert property (RD && ADDR == IFB_OFF_FLAGS4 |=>
    RDATA[15:8] == 8'h00 && !RDATA[3])
    else $error("absent bits of flag word 4 not zero");
  a_en0_gap: assert property (RD && ADDR == IFB_OFF_EN0 |=> !RDATA[15])
    else $error("absent enable bit not zero");
  // the flag is visible to a read issued in the very next cycle
  a_event_sticks: assert property (
    TIMER_SEVEN_FLAG ##1 (RD && ADDR == IFB_OFF_FLAGS3) |=> RDATA[0])
    else $error("event did not set its flag");
  a_irq_follows: assert property (REQ_TIMER_SEVEN |=> IRQ)
    else $error("request did not raise the interrupt");
  a_word0_gate: assert property (REQ_EXT_IRQ0 |-> $past(FLAGS_W0[0]))
    else $error("word 0 request without its flag");
endmodule

// [tb/ifb_src.sv]
`timescale 1ns/100ps
// event sources: each burst request becomes one cycle of event lines
module ifb_src (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [15:0] pat2,
  input  wire logic [15:0] pat3,
  input  wire logic [15:0] pat4,
  output logic      [15:0] ev2,
  output logic      [15:0] ev3,
  output logic      [15:0] ev4
);
  // low between bursts, so a flag that fails to stick shows up
  always_ff @(posedge clk) begin
    ev2 <= go ? pat2 : 16'h0000;
    ev3 <= go ? pat3 : 16'h0000;
    ev4 <= go ? pat4 : 16'h0000;
  end
endmodule

// [tb/test_ifb_bank.sv]
`timescale 1ns/100ps
module test_ifb_bank;
  import ifb_pkg::*;
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic [7:0]  ADDR = 8'h00;
  logic [15:0] WDATA = 16'h0000;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic [15:0] FLAGS_W0 = 16'h0000;
  logic        go = 1'b0;
  logic [15:0] p2 = 16'h0000, p3 = 16'h0000, p4 = 16'h0000;
  logic [15:0] RDATA, e2, e3, e4, d;
  wire  [15:0] r0, r2, r3, r4;
  logic        IRQ;
  logic [15:0] m [0:6];
  logic [15:0] msk [0:6];
  int          n_mismatch = 0;
  int          checks_done = 0;

  always #2.5 CLK = ~CLK;

  // positions with no request line compare as zero
  assign r0[15]    = 1'b0;
  assign r2[15:3]  = 13'h0000;
  assign r3[14]    = 1'b0;
  assign r3[12:11] = 2'h0;
  assign r4[15:8]  = 8'h00;
  assign r4[3]     = 1'b0;

  ifb_src i_ifb_src (.clk(CLK), .go(go), .pat2(p2), .pat3(p3), .pat4(p4),
    .ev2(e2), .ev3(e3), .ev4(e4));

  ifb_bank i_ifb_bank (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .FLAGS_W0(FLAGS_W0),
    .CAN1_RX_READY_FLAG(e2[2]), .SERIAL_PERIPH2_EVENT_FLAG(e2[1]),
    .SERIAL_PERIPH2_ERROR_FLAG(e2[0]), .MOTOR_FAULT_A_FLAG(e3[15]),
    .DMA_CH5_DONE_FLAG(e3[13]), .ENCODER_EVENT_FLAG(e3[10]), .MOTOR_PWM_ERROR_FLAG(e3[9]),
    .CAN2_EVENT_FLAG(e3[8]), .CAN2_RX_READY_FLAG(e3[7]), .EXT_IRQ4_FLAG(e3[6]),
    .EXT_IRQ3_FLAG(e3[5]), .TIMER_NINE_FLAG(e3[4]), .TIMER_EIGHT_FLAG(e3[3]),
    .I2C_SECOND_MASTER_FLAG(e3[2]), .I2C_SECOND_SLAVE_FLAG(e3[1]), .TIMER_SEVEN_FLAG(e3[0]),
    .CAN2_TX_REQUEST_FLAG(e4[7]), .CAN1_TX_REQUEST_FLAG(e4[6]), .DMA_CH7_DONE_FLAG(e4[5]),
    .DMA_CH6_DONE_FLAG(e4[4]), .UART_SECOND_ERROR_FLAG(e4[2]),
    .UART_FIRST_ERROR_FLAG(e4[1]), .MOTOR_FAULT_B_FLAG(e4[0]),
    .REQ_CAN1_RX_READY(r2[2]), .REQ_SERIAL_PERIPH2_EVENT(r2[1]),
    .REQ_SERIAL_PERIPH2_ERROR(r2[0]), .REQ_MOTOR_FAULT_A(r3[15]), .REQ_DMA_CH5_DONE(r3[13]),
    .REQ_ENCODER_EVENT(r3[10]), .REQ_MOTOR_PWM_ERROR(r3[9]), .REQ_CAN2_EVENT(r3[8]),
    .REQ_CAN2_RX_READY(r3[7]), .REQ_EXT_IRQ4(r3[6]), .REQ_EXT_IRQ3(r3[5]),
    .REQ_TIMER_NINE(r3[4]), .REQ_TIMER_EIGHT(r3[3]), .REQ_I2C_SECOND_MASTER(r3[2]),
    .REQ_I2C_SECOND_SLAVE(r3[1]), .REQ_TIMER_SEVEN(r3[0]), .REQ_CAN2_TX_REQUEST(r4[7]),
    .REQ_CAN1_TX_REQUEST(r4[6]), .REQ_DMA_CH7_DONE(r4[5]), .REQ_DMA_CH6_DONE(r4[4]),
    .REQ_UART_SECOND_ERROR(r4[2]), .REQ_UART_FIRST_ERROR(r4[1]),
    .REQ_MOTOR_FAULT_B(r4[0]), .REQ_DMA_CH1_DONE(r0[14]), .REQ_ADC_FIRST_DONE(r0[13]),
    .REQ_UART_FIRST_TX(r0[12]), .REQ_UART_FIRST_RX(r0[11]),
    .REQ_SERIAL_PERIPH1_EVENT(r0[10]), .REQ_SERIAL_PERIPH1_ERROR(r0[9]),
    .REQ_TIMER_THREE(r0[8]), .REQ_TIMER_TWO(r0[7]), .REQ_OUT_COMPARE2(r0[6]),
    .REQ_IN_CAPTURE2(r0[5]), .REQ_DMA_CH0_DONE(r0[4]), .REQ_TIMER_ONE(r0[3]),
    .REQ_OUT_COMPARE1(r0[2]), .REQ_IN_CAPTURE1(r0[1]), .REQ_EXT_IRQ0(r0[0]));

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle strobes; the gap cycle keeps a strobe from being driven twice
  task automatic wr(logic [7:0] a, logic [15:0] v);
    @(posedge CLK) begin WR <= 1'b1; ADDR <= a; WDATA <= v; end
    @(posedge CLK) WR <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, output logic [15:0] v);
    @(posedge CLK) begin RD <= 1'b1; ADDR <= a; end
    @(posedge CLK) RD <= 1'b0;
    #1 v = RDATA;
  endtask

  // every register, one unmapped place, all request lines and the interrupt
  task automatic check_all();
    for (int a = 0; a < 10; a++) begin
      rd(8'(a), d);
      check("register", d, (a < 7) ? m[a] : 16'h0000);
    end
    rd(8'hff, d);
    check("unmapped", d, 16'h0000);
    check("req word0", r0 & msk[3], FLAGS_W0 & m[3]);
    check("req word2", r2 & msk[0], m[0] & m[4]);
    check("req word3", r3 & msk[1], m[1] & m[5]);
    check("req word4", r4 & msk[2], m[2] & m[6]);
    check("irq", {15'h0000, IRQ},
      {15'h0000, |{FLAGS_W0 & m[3], m[0] & m[4], m[1] & m[5], m[2] & m[6]}});
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // a hang costs a mismatch; the tests need well under a thousand cycles
  initial begin
    #25000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    msk = '{IFB_IMPL_W2, IFB_IMPL_W3, IFB_IMPL_W4, IFB_IMPL_EN0, IFB_IMPL_W2, IFB_IMPL_W3,
      IFB_IMPL_W4};
    m = '{default: IFB_RST_WORD};
    d = 16'($urandom(51));
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    check_all();
    $display("test reset values done");
    // all-ones first, so absent bits are hit, then random words
    for (int k = 0; k < 4; k++) begin
      for (int a = 0; a < 7; a++) begin
        d = (k == 0) ? 16'hffff : 16'($urandom);
        wr(8'(a), d);
        m[a] = d & msk[a];
      end
      @(posedge CLK) FLAGS_W0 <= 16'($urandom);
      check_all();
    end
    $display("test register access done");
    // event bursts under changing enables, then clears through each clear word
    for (int k = 0; k < 9; k++) begin
      d = (k == 0) ? 16'hffff : 16'($urandom);
      wr(IFB_OFF_EN3, d);
      m[5] = d & msk[5];
      @(posedge CLK) begin
        p2 <= 16'($urandom);
        p3 <= (k == 0) ? 16'hffff : 16'($urandom);
        p4 <= 16'($urandom);
        go <= 1'b1;
      end
      @(posedge CLK) go <= 1'b0;
      m[0] = m[0] | (p2 & msk[0]);
      m[1] = m[1] | (p3 & msk[1]);
      m[2] = m[2] | (p4 & msk[2]);
      rd(IFB_OFF_FLAGS3, d);
      check("flags word3", d, m[1]);
      check_all();
      d = 16'($urandom);
      wr(IFB_OFF_CLR2 + 8'(k % 3), d);
      m[k % 3] = m[k % 3] & ~d;
      check_all();
    end
    $display("test events and clears done");
    // events and a full clear of word 3 land on the same edge: the set must win
    @(posedge CLK) begin
      p3 <= 16'hffff;
      go <= 1'b1;
    end
    @(posedge CLK) begin
      go <= 1'b0;
      WR <= 1'b1;
      ADDR <= IFB_OFF_CLR3;
      WDATA <= 16'hffff;
    end
    @(posedge CLK) WR <= 1'b0;
    m[1] = msk[1];
    rd(IFB_OFF_FLAGS3, d);
    check("set beats clear", d, m[1]);
    $display("test set against clear done");
    // reset in mid-run, with flags and enables set, must clear them all again
    @(posedge CLK) RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    m = '{default: IFB_RST_WORD};
    check_all();
    $display("test reset in mid-run done");
    stop_test();
  end
endmodule

bind ifb_bank ifb_bank_props i_props (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .RD(RD),
  .RDATA(RDATA), .IRQ(IRQ), .FLAGS_W0(FLAGS_W0), .TIMER_SEVEN_FLAG(TIMER_SEVEN_FLAG),
  .REQ_TIMER_SEVEN(REQ_TIMER_SEVEN), .REQ_EXT_IRQ0(REQ_EXT_IRQ0));
